// >>> logic/tws_pkg.sv
// Purpose: Shared constants and types for the two-wire memory slave
// Assumes: 40 MHz system clock, bus pins sampled by that clock
// Notes:   Offsets, field positions and some reset values live here; others are set in the slave
`default_nettype none

package tws_pkg;

  // ==========================================================
  // Array geometry
  localparam int         MEM_DEPTH = 512;
  localparam int         ADDR_W    = 9;
  localparam logic [8:0] ADDR_RST  = 9'h000;
  localparam logic [8:0] ADDR_ONE  = 9'h001;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ONE   = 4'h1;
  localparam logic [3:0] CNT_RST   = 4'h0;

  // ==========================================================
  // Slave address byte fields
  localparam int SA_RW     = 0;
  localparam int SA_PAGE   = 1;
  localparam int SA_SEL_LO = 2;
  localparam int SA_SEL_HI = 3;
  localparam int SA_TYPE_L = 4;
  localparam int SA_TYPE_H = 7;

  // ==========================================================
  // Synchroniser lanes
  localparam int IX_SCL = 0;
  localparam int IX_SDA = 1;
  localparam int IX_WP  = 2;
  localparam int IX_SLO = 3;
  localparam int IX_SHI = 4;
  localparam int SYNC_W = 5;
  localparam logic [4:0] SYNC_RST = 5'h03;

  // ==========================================================
  // Register port map
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STAT   = 4'h1;
  localparam int          CTRL_EN    = 0;
  localparam logic        CTRL_EN_RST = 1'b1;
  localparam logic [15:0] RD_ZERO    = 16'h0000;
  localparam logic [4:0]  STAT_PAD   = 5'h00;

  // ==========================================================
  // Protocol states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_DEV   = 7'h02,
    ST_ACK   = 7'h04,
    ST_WA    = 7'h08,
    ST_WR    = 7'h10,
    ST_RD    = 7'h20,
    ST_RDACK = 7'h40
  } tws_state_t;

endpackage : tws_pkg

`default_nettype wire

// >>> logic/tws_slave.sv
// Purpose: Slave end of a two-wire bus in front of a 512 x 8 byte array
// Assumes: Pins are asynchronous and sampled by clk_sys; SCL far slower
// Notes:   SDA is open drain: sdaOut is always low, sdaOe pulls the wire
`default_nettype none

module tws_slave
  import tws_pkg::*;
#(
  // Device type code; value is arbitrary
  parameter logic [3:0] DevType = 4'h6
) (
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // Two-wire bus pins
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // Strap and protect pins
  input  wire logic        wp,
  input  wire logic        selPinLow,
  input  wire logic        selPinHigh,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic [15:0]      regRdData
);

  // ==========================================================
  // Pin synchronisers
  logic [SYNC_W-1:0] sync1Q;
  logic [SYNC_W-1:0] sync2Q;
  logic              sclD;
  logic              sdaD;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync1Q <= SYNC_RST;
      sync2Q <= SYNC_RST;
      sclD   <= 1'b1;
      sdaD   <= 1'b1;
    end else if (ce) begin
      sync1Q <= {selPinHigh, selPinLow, wp, sdaIn, scl};
      sync2Q <= sync1Q;
      sclD   <= sync2Q[IX_SCL];
      sdaD   <= sync2Q[IX_SDA];
    end
  end

  wire sclS   = sync2Q[IX_SCL];
  wire sdaS   = sync2Q[IX_SDA];
  wire wpS    = sync2Q[IX_WP];
  wire selLoS = sync2Q[IX_SLO];
  wire selHiS = sync2Q[IX_SHI];

  // ==========================================================
  // Bus conditions
  wire sclRise  = sclS & ~sclD;
  wire sclFall  = ~sclS & sclD;
  wire startDet = sclS & sclD & sdaD & ~sdaS;
  wire stopDet  = sclS & sclD & ~sdaD & sdaS;

  // ==========================================================
  // State and datapath registers
  tws_state_t stateQ;
  tws_state_t stateD;
  tws_state_t ackNextQ;
  tws_state_t ackNextD;
  logic [3:0] bitCntQ;
  logic [3:0] bitCntD;
  logic [7:0] shQ;
  logic [7:0] shD;
  logic [8:0] addrQ;
  logic [8:0] addrD;
  logic       oeQ;
  logic       oeD;
  logic       ackSeenQ;
  logic       ackSeenD;
  logic       rwQ;
  logic       rwD;
  logic       enQ;

  // ==========================================================
  // Byte array
  logic [7:0] mem [MEM_DEPTH];

  wire       byteDone = (bitCntQ == BYTE_BITS);
  wire [7:0] memRd    = mem[addrQ];
  wire [8:0] addrInc  = addrQ + ADDR_ONE;

  wire typeOk = (shQ[SA_TYPE_H:SA_TYPE_L] == DevType);
  wire selOk  = (shQ[SA_SEL_HI] == selHiS) &&
                (shQ[SA_SEL_LO] == selLoS);
  wire devMatch = typeOk && selOk;

  wire inByte = (stateQ == ST_DEV) || (stateQ == ST_WA) ||
                (stateQ == ST_WR);

  // Array written at the byte's last fall: done before the ack
  wire wrEn = ce && enQ && !startDet && !stopDet &&
              (stateQ == ST_WR) && sclFall && byteDone &&
              !wpS;

  // ==========================================================
  // Next-state logic
  always_comb begin
    stateD   = stateQ;
    ackNextD = ackNextQ;
    bitCntD  = bitCntQ;
    shD      = shQ;
    addrD    = addrQ;
    oeD      = oeQ;
    ackSeenD = ackSeenQ;
    rwD      = rwQ;
    if (!enQ) begin
      stateD = ST_IDLE;
      oeD    = 1'b0;
    end else if (startDet) begin
      stateD  = ST_DEV;
      bitCntD = CNT_RST;
      oeD     = 1'b0;
    end else if (stopDet) begin
      stateD = ST_IDLE;
      oeD    = 1'b0;
    end else begin
      case (stateQ)
        ST_DEV, ST_WA, ST_WR: begin
          if (sclRise) begin
            shD     = {shQ[6:0], sdaS};
            bitCntD = bitCntQ + CNT_ONE;
          end else if (sclFall && byteDone) begin
            bitCntD = CNT_RST;
            case (stateQ)
              ST_DEV: begin
                if (devMatch) begin
                  addrD[8] = shQ[SA_PAGE];
                  rwD      = shQ[SA_RW];
                  // Read skips the word address byte
                  ackNextD = shQ[SA_RW] ? ST_RD : ST_WA;
                  oeD      = 1'b1;
                  stateD   = ST_ACK;
                end else begin
                  stateD = ST_IDLE;
                end
              end
              ST_WA: begin
                addrD    = {addrQ[8], shQ};
                ackNextD = ST_WR;
                oeD      = 1'b1;
                stateD   = ST_ACK;
              end
              default: begin
                if (!wpS) begin
                  addrD    = addrInc;
                  ackNextD = ST_WR;
                  oeD      = 1'b1;
                  stateD   = ST_ACK;
                end else begin
                  stateD = ST_IDLE;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            bitCntD = CNT_RST;
            stateD  = ackNextQ;
            if (ackNextQ == ST_RD) begin
              shD = memRd;
              oeD = ~memRd[7];
            end else begin
              oeD = 1'b0;
            end
          end
        end
        ST_RD: begin
          if (sclRise) begin
            bitCntD = bitCntQ + CNT_ONE;
          end else if (sclFall) begin
            if (byteDone) begin
              oeD      = 1'b0;
              addrD    = addrInc;
              ackSeenD = 1'b0;
              stateD   = ST_RDACK;
            end else begin
              shD = {shQ[6:0], 1'b0};
              oeD = ~shQ[6];
            end
          end
        end
        ST_RDACK: begin
          if (sclRise) begin
            ackSeenD = ~sdaS;
          end else if (sclFall) begin
            if (ackSeenQ) begin
              bitCntD = CNT_RST;
              shD     = memRd;
              oeD     = ~memRd[7];
              stateD  = ST_RD;
            end else begin
              stateD = ST_IDLE;
            end
          end
        end
        default: begin
          stateD = ST_IDLE;
          oeD    = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Protocol registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ   <= ST_IDLE;
      ackNextQ <= ST_WA;
      bitCntQ  <= CNT_RST;
      shQ      <= 8'h00;
      oeQ      <= 1'b0;
      ackSeenQ <= 1'b0;
      rwQ      <= 1'b0;
    end else if (ce) begin
      stateQ   <= stateD;
      ackNextQ <= ackNextD;
      bitCntQ  <= bitCntD;
      shQ      <= shD;
      oeQ      <= oeD;
      ackSeenQ <= ackSeenD;
      rwQ      <= rwD;
    end
  end

  // Address held across transactions for current reads
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      addrQ <= ADDR_RST;
    end else if (ce) begin
      addrQ <= addrD;
    end
  end

  // Array has no reset: contents survive bus aborts
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[addrQ] <= shQ;
    end
  end

  // Only a pull-down is ever driven; SCL has no driver at all
  assign sdaOut = 1'b0;
  assign sdaOe  = oeQ;

  // ==========================================================
  // Register port
  wire ctrlSel = (regAddr == REG_CTRL);
  wire statSel = (regAddr == REG_STAT);
  wire busy    = (stateQ != ST_IDLE);

  wire [15:0] statWord = {STAT_PAD, rwQ, busy, addrQ};
  wire [15:0] ctrlWord = {15'h0000, enQ};
  wire [15:0] rdMux    = ctrlSel ? ctrlWord :
                         statSel ? statWord : RD_ZERO;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      enQ <= CTRL_EN_RST;
    end else if (ce && regWrStb && ctrlSel) begin
      enQ <= regWrData[CTRL_EN];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= RD_ZERO;
    end else if (ce && regRdStb) begin
      regRdData <= rdMux;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence sDevDone;
    ce && enQ && !startDet && !stopDet && stateQ == ST_DEV &&
    sclFall && byteDone;
  endsequence

  sequence sWaDone;
    ce && enQ && !startDet && !stopDet && stateQ == ST_WA &&
    sclFall && byteDone;
  endsequence

  sequence sRdNack;
    ce && enQ && !startDet && !stopDet && stateQ == ST_RDACK &&
    sclFall && !ackSeenQ;
  endsequence

  a_idle_released: assert property (
    stateQ == ST_IDLE |-> !sdaOe)
    else $error("SDA pulled while idle");

  a_start_abort: assert property (
    ce && enQ && startDet |=> stateQ == ST_DEV && !sdaOe &&
    bitCntQ == CNT_RST)
    else $error("start did not reset to address phase");

  a_stop_idle: assert property (
    ce && enQ && stopDet |=> stateQ == ST_IDLE)
    else $error("stop did not abort");

  a_oe_on_fall: assert property (
    $changed(sdaOe) |-> $past(sclFall || startDet || stopDet || !enQ))
    else $error("SDA drive changed away from SCL fall");

  a_dev_match: assert property (
    sDevDone |=> (stateQ == ST_ACK) == $past(devMatch) &&
    sdaOe == $past(devMatch))
    else $error("slave address match handled wrongly");

  a_page_latch: assert property (
    sDevDone ##0 devMatch |=> addrQ[8] == $past(shQ[SA_PAGE]) &&
    ackNextQ == ($past(shQ[SA_RW]) ? ST_RD : ST_WA))
    else $error("page or direction not latched");

  a_word_addr: assert property (
    sWaDone |=> sdaOe && stateQ == ST_ACK &&
    addrQ[7:0] == $past(shQ) ##0 ackNextQ == ST_WR)
    else $error("word address not latched and acked");

  // Whole protected data phase: address frozen, line never pulled
  a_wp_block: assert property (
    ce && enQ && wpS && stateQ == ST_WR |=> $stable(addrQ) && !sdaOe)
    else $error("write phase moved while protected");

  a_wp_noack: assert property (
    ce && enQ && !startDet && !stopDet && stateQ == ST_WR &&
    sclFall && byteDone && wpS |=> !sdaOe && addrQ == $past(addrQ))
    else $error("protected write acked or counted");

  a_addr_wrap: assert property (
    wrEn |=> addrQ == ADDR_W'($past(addrQ) + ADDR_ONE) && sdaOe)
    else $error("address did not advance after write");

  a_rd_nack: assert property (
    sRdNack |=> stateQ == ST_IDLE ##1 !sdaOe)
    else $error("read continued after no-acknowledge");

endmodule : tws_slave

`default_nettype wire

// >>> test/two_wire_memory_slave_tb.sv
// Purpose: Self-checking bench for the two-wire memory slave
// Assumes: Master model drives SCL and SDA, pull-up on SDA
// Notes:   Drivers queue expectations, one watcher compares
`default_nettype none

module two_wire_memory_slave_tb
  import tws_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [3:0] DEV_TYPE = 4'h6; // Arbitrary type code

  logic        clk_sys, sys_rst, ce, wp, selPinLow, selPinHigh, regWrStb, regRdStb, rdSeen;
  logic [3:0]  regAddr;
  logic [15:0] regWrData, exp16;
  logic [8:0]  exp9, a9;
  logic [31:0] rnd;
  logic [7:0]  mirror [0:511];
  logic [8:0]  busQ [$];
  logic [15:0] regQ [$];
  int          n_fail, comparisons;
  int          seed = 32'h2df86f2b;
  wire logic [15:0] regRdData;
  wire logic        sdaOut, sdaOe, scl, mPull, rxValid;
  wire logic [8:0]  rxData;
  // Wired-AND with pull-up
  wire logic        sdaWire = ~(mPull | sdaOe);

  tws_slave #(.DevType(DEV_TYPE)) tws_slave_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .scl(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .wp(wp), .selPinLow(selPinLow),
    .selPinHigh(selPinHigh), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData));

  tws_bus_master tws_bus_master_i (
    .clk_sys(clk_sys), .sdaWire(sdaWire), .scl(scl), .sdaPull(mPull),
    .rxValid(rxValid), .rxData(rxData));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Watcher
  always @(posedge clk_sys) begin
    rdSeen <= regRdStb;
    comparisons++;
    if (sdaOut !== 1'b0) begin
      n_fail++;
      $display("[FAIL] %0t data pin driven high", $time);
    end
    if (rdSeen) begin
      exp16 = (regQ.size() > 0) ? regQ.pop_front() : 16'hXXXX;
      comparisons++;
      if (regRdData !== exp16) begin
        n_fail++;
        $display("[FAIL] %0t reg read %h exp %h", $time, regRdData, exp16);
      end
    end
    if (rxValid) begin
      exp9 = (busQ.size() > 0) ? busQ.pop_front() : 9'hXXX;
      comparisons++;
      if (rxData !== exp9) begin
        n_fail++;
        $display("[FAIL] %0t bus byte %h exp %h", $time, rxData, exp9);
      end
    end
  end

  // ==========================================================
  // Drivers
  task automatic regWr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
  endtask : regWr

  task automatic regRd(input logic [3:0] a, input logic [15:0] e);
    regQ.push_back(e);
    @(posedge clk_sys);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
  endtask : regRd

  function automatic logic [15:0] st(input logic [8:0] a, input logic rw);
    return {STAT_PAD, rw, 1'b0, a};
  endfunction : st

  function automatic logic [7:0] sa(input logic p, input logic rw);
    return {DEV_TYPE, selPinHigh, selPinLow, p, rw};
  endfunction : sa

  task automatic sendByte(input logic [7:0] d, input logic ackExp);
    busQ.push_back({d, ackExp});
    tws_bus_master_i.xferByte(d, 1'b1);
  endtask : sendByte

  task automatic readByte(input logic [7:0] e, input logic ackOut);
    busQ.push_back({e, ackOut});
    tws_bus_master_i.xferByte(8'hFF, ackOut);
  endtask : readByte

  task automatic setAddr(input logic p, input logic [7:0] w);
    tws_bus_master_i.busStart();
    sendByte(sa(p, 1'b0), 1'b0);
    sendByte(w, 1'b0);
  endtask : setAddr

  // Repeated start turns the write into a read of 1FE, 1FF
  task automatic selRead2();
    setAddr(1'b1, 8'hFE);
    tws_bus_master_i.busStart();
    sendByte(sa(1'b1, 1'b1), 1'b0);
    readByte(mirror[9'h1FE], 1'b0);
    readByte(mirror[9'h1FF], 1'b1);
    tws_bus_master_i.busStop();
    regRd(REG_STAT, st(ADDR_RST, 1'b1));
  endtask : selRead2

  task automatic wrap_up();
    if (busQ.size() != 0 || regQ.size() != 0) begin
      n_fail++;
      $display("[FAIL] %0t results missing", $time);
    end
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    wp = 1'b0;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    rdSeen = 1'b0;
    rnd = $random(seed);
    selPinLow = rnd[0];
    selPinHigh = rnd[1];
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    regRd(REG_CTRL, {15'h0000, CTRL_EN_RST});
    regRd(4'h5, RD_ZERO);
    // Enable low: strobes ignored, read data and enable kept
    ce <= 1'b0;
    regWr(REG_CTRL, 16'h0000);
    regRd(REG_CTRL, RD_ZERO);
    ce <= 1'b1;
    regWr(REG_STAT, 16'hFFFF);
    regRd(REG_STAT, st(ADDR_RST, 1'b0));
    // Three bytes across the top of the array
    setAddr(1'b1, 8'hFE);
    for (int i = 0; i < 3; i++) begin
      rnd = $random(seed);
      a9 = 9'h1FE + 9'(i);
      mirror[a9] = rnd[7:0];
      sendByte(rnd[7:0], 1'b0);
    end
    tws_bus_master_i.busStop();
    regRd(REG_STAT, st(ADDR_ONE, 1'b0));
    selRead2();
    // Protected write refused, address held
    wp <= 1'b1;
    setAddr(1'b1, 8'hFE);
    // Mid-frame status shows busy
    regRd(REG_STAT, {STAT_PAD, 1'b0, 1'b1, 9'h1FE});
    sendByte(~mirror[9'h1FE], 1'b1);
    tws_bus_master_i.busStop();
    regRd(REG_STAT, st(9'h1FE, 1'b0));
    wp <= 1'b0;
    // Stop inside a data byte
    setAddr(1'b1, 8'hFF);
    tws_bus_master_i.partBits(~mirror[9'h1FF], 4);
    tws_bus_master_i.busStop();
    regRd(REG_STAT, st(9'h1FF, 1'b0));
    selRead2();
    // Nack ends read; next byte finds the line released
    tws_bus_master_i.busStart();
    sendByte(sa(1'b0, 1'b1), 1'b0);
    readByte(mirror[9'h000], 1'b1);
    readByte(8'hFF, 1'b1);
    tws_bus_master_i.busStop();
    // Wrong type, high select, low select
    for (int k = 0; k < 3; k++) begin
      tws_bus_master_i.busStart();
      sendByte({(k == 0) ? ~DEV_TYPE : DEV_TYPE, selPinHigh ^ (k == 1),
                selPinLow ^ (k == 2), 2'b00}, 1'b1);
      sendByte(8'h00, 1'b1);
      tws_bus_master_i.busStop();
    end
    // Disabled block ignores the bus
    regWr(REG_CTRL, 16'h0000);
    tws_bus_master_i.busStart();
    sendByte(sa(1'b0, 1'b0), 1'b1);
    tws_bus_master_i.busStop();
    regWr(REG_CTRL, 16'h0001);
    regRd(REG_CTRL, 16'h0001);
    repeat (4) @(posedge clk_sys);
    wrap_up();
  end

endmodule : two_wire_memory_slave_tb

`default_nettype wire

// >>> test/tws_bus_master.sv
// Purpose: Behavioural two-wire bus master facing the slave
// Assumes: SDA pull-up, wire level formed by the bench
// Notes:   SCL rests high between frames; 8 clk_sys per bit
`default_nettype none

module tws_bus_master (
  // Clock
  input  wire logic       clk_sys,
  // Bus
  input  wire logic       sdaWire,
  output var  logic       scl,
  output var  logic       sdaPull,
  // Each byte as seen on the wire, ack bit last
  output var  logic       rxValid,
  output var  logic [8:0] rxData
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
    rxValid = 1'b0;
    rxData = 9'h000;
  end

  always @(posedge clk_sys) begin
    if (rxValid) begin
      rxValid <= 1'b0;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // ==========================================================
  // Bit level
  // SDA moves mid low phase, far from both SCL edges
  task automatic bitCycle(input logic b, output logic seen);
    tick(2);
    sdaPull <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    seen = sdaWire;
    scl <= 1'b0;
  endtask : bitCycle

  task automatic busStart();
    tick(2);
    sdaPull <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdaPull <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask : busStart

  // Only called while the master owns SDA
  task automatic busStop();
    tick(2);
    sdaPull <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdaPull <= 1'b0;
    tick(4);
  endtask : busStop

  // ==========================================================
  // Byte level: ackBit low acknowledges a read byte
  task automatic xferByte(input logic [7:0] d, input logic ackBit);
    logic [8:0] tx;
    logic [8:0] got;
    tx = {d, ackBit};
    for (int i = 8; i >= 0; i--) begin
      bitCycle(tx[i], got[i]);
    end
    rxData <= got;
    rxValid <= 1'b1;
  endtask : xferByte

  task automatic partBits(input logic [7:0] d, input int n);
    logic seen;
    for (int i = 7; i > 7 - n; i--) begin
      bitCycle(d[i], seen);
    end
  endtask : partBits

endmodule : tws_bus_master

`default_nettype wire
